//--- hw/scr_control_regs.sv
// synthesizer control register bank: main control word, cal divider, fixed config
// assumes an APB master on ref_clk; downstream blocks consume the control struct
`timescale 1ns/10ps

module scr_control_regs
   import scr_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // device status pins
   input  wire logic        lockDetectIn,
   input  wire logic        readbackBitIn,
   input  wire logic        calBusyIn,
   // control outputs
   output scr_ctrl_s        ctrl,
   output logic             multiplexedOutputPin,
   output logic             rfMute,
   output logic             calSmClockEnable
);

   // ***********************************************************
   // decode
   // ***********************************************************
   function automatic logic [1:0] decodeIndex(input logic [11:0] addr, output logic hit);
      hit = 1'b1;
      decodeIndex = 2'h3;
      unique case (addr)
         `SCR_ADDR_MAIN   : decodeIndex = `SCR_IDX_MAIN;
         `SCR_ADDR_CALDIV : decodeIndex = `SCR_IDX_CALDIV;
         `SCR_ADDR_FIXED2 : decodeIndex = `SCR_IDX_FIXED2;
         default          : hit = 1'b0;
      endcase
   endfunction : decodeIndex

   // apply byte strobes to a 16-bit word
   function automatic scr_word_t mergeBytes(input scr_word_t old, input logic [31:0] wd,
                                            input logic [3:0] strb);
      mergeBytes = old;
      if (strb[0]) begin
         mergeBytes[7:0] = wd[7:0];
      end
      if (strb[1]) begin
         mergeBytes[15:8] = wd[15:8];
      end
   endfunction : mergeBytes

   scr_word_t  mainWord;
   scr_word_t  calDivWord;
   scr_word_t  fixedTwoWord;
   scr_state_e state;
   scr_state_e next_state;
   logic       addrHit;
   logic [1:0] regIndex;
   logic       accessDone;
   logic       writeMain;
   scr_word_t  next_main;
   logic       lockMeta;
   logic       lockSync;
   logic       rbMeta;
   logic       rbSync;
   logic       busyMeta;
   logic       busySync;
   logic [7:0] divCount;
   logic [7:0] divLimit;
   logic       softReset;
   logic       writeCalDiv;
   logic       writeFixedTwo;
   logic       loadRead;

   always_comb begin
      regIndex = decodeIndex(paddr, addrHit);
   end

   // ***********************************************************
   // apb handshake: one wait state, then ready
   // ***********************************************************
   always_comb begin
      next_state = state;
      unique case (state)
         SCR_IDLE   : if (psel && !penable) next_state = SCR_ACCESS;
         SCR_ACCESS : next_state = SCR_DONE;
         SCR_DONE   : next_state = (psel && !penable) ? SCR_ACCESS : SCR_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= SCR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign pready     = (state == SCR_DONE) && psel && penable;
   assign pslverr    = pready && !addrHit;
   assign accessDone = pready && addrHit;
   assign writeMain  = accessDone && pwrite && (regIndex == `SCR_IDX_MAIN);

   always_comb begin
      next_main = mergeBytes(mainWord, pwdata, pstrb);
   end

   // ***********************************************************
   // write strobes and read load
   // ***********************************************************
   // soft reset rides on the same completed write as every other side effect
   assign softReset     = writeMain && next_main[`SCR_B_SOFT_RESET];
   assign writeCalDiv   = accessDone && pwrite && (regIndex == `SCR_IDX_CALDIV);
   assign writeFixedTwo = accessDone && pwrite && (regIndex == `SCR_IDX_FIXED2);
   // read data is loaded in the wait cycle so it stands when pready rises
   assign loadRead      = (state == SCR_ACCESS) && psel && !pwrite;

   // ***********************************************************
   // registers
   // ***********************************************************
   // main control word; the default has the reset bit clear, so the
   // bit reads back zero after a soft reset without further logic
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mainWord <= `SCR_RST_MAIN;
      end else if (softReset) begin
         mainWord <= `SCR_RST_MAIN;
      end else if (writeMain) begin
         mainWord <= next_main;
      end
   end

   // calibration divider; soft reset wins over nothing here, since a
   // write to this word and a soft reset never share a cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         calDivWord <= `SCR_RST_CALDIV;
      end else if (softReset) begin
         calDivWord <= `SCR_RST_CALDIV;
      end else if (writeCalDiv) begin
         calDivWord <= mergeBytes(calDivWord, pwdata, pstrb);
      end
   end

   // fixed configuration word, restored by soft reset as well
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fixedTwoWord <= `SCR_RST_FIXED2;
      end else if (softReset) begin
         fixedTwoWord <= `SCR_RST_FIXED2;
      end else if (writeFixedTwo) begin
         fixedTwoWord <= mergeBytes(fixedTwoWord, pwdata, pstrb);
      end
   end

   // ***********************************************************
   // read data
   // ***********************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (loadRead) begin
         unique case (regIndex)
            `SCR_IDX_MAIN   : prdata <= {16'h0000, mainWord};
            `SCR_IDX_CALDIV : prdata <= {16'h0000, calDivWord};
            `SCR_IDX_FIXED2 : prdata <= {16'h0000, fixedTwoWord};
            default         : prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ***********************************************************
   // write side effects, one-cycle pulses
   // ***********************************************************
   // every completed main-word write with the go bit starts a ramp, even
   // one meant only to retrigger calibration
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl.rampStart <= 1'b0;
      end else begin
         ctrl.rampStart <= writeMain && next_main[`SCR_B_RAMP_GO];
      end
   end

   // calibration restarts on each write carrying the trigger bit
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl.calStart <= 1'b0;
      end else begin
         ctrl.calStart <= writeMain && next_main[`SCR_B_CAL_TRIGGER];
      end
   end

   // sync pulse only on a zero-to-one change of the stored enable bit
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl.syncPulse <= 1'b0;
      end else begin
         ctrl.syncPulse <= writeMain && next_main[`SCR_B_PHASE_SYNC]
                           && !mainWord[`SCR_B_PHASE_SYNC];
      end
   end

   // ***********************************************************
   // static controls
   // ***********************************************************
   // levels from the main word, one cycle behind the register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl.phaseSyncEnable  <= 1'b0;
         ctrl.addrFreeze       <= 1'b0;
         ctrl.calOutputMute    <= 1'b1;
         ctrl.highPdRange      <= 2'b00;
         ctrl.lowPdRange       <= 2'b00;
         ctrl.readoutPinSelect <= 1'b1;
         ctrl.sleepRequest     <= 1'b0;
      end else begin
         ctrl.phaseSyncEnable  <= mainWord[`SCR_B_PHASE_SYNC];
         ctrl.addrFreeze       <= mainWord[`SCR_B_ADDR_FREEZE];
         ctrl.calOutputMute    <= mainWord[`SCR_B_OUT_MUTE];
         ctrl.highPdRange      <= mainWord[`SCR_B_HPD_HI:`SCR_B_HPD_LO];
         ctrl.lowPdRange       <= mainWord[`SCR_B_LPD_HI:`SCR_B_LPD_LO];
         ctrl.readoutPinSelect <= mainWord[`SCR_B_READOUT_SEL];
         ctrl.sleepRequest     <= mainWord[`SCR_B_SLEEP];
      end
   end

   // divider code for the calibration engine
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl.calClockDiv <= 3'h0;
      end else begin
         ctrl.calClockDiv <= calDivWord[`SCR_B_DIV_HI:`SCR_B_DIV_LO];
      end
   end

   // ***********************************************************
   // pin inputs synchronised
   // ***********************************************************
   // only the second flop of each pair is read by logic
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lockMeta <= 1'b0;
         lockSync <= 1'b0;
      end else begin
         lockMeta <= lockDetectIn;
         lockSync <= lockMeta;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rbMeta <= 1'b0;
         rbSync <= 1'b0;
      end else begin
         rbMeta <= readbackBitIn;
         rbSync <= rbMeta;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busyMeta <= 1'b0;
         busySync <= 1'b0;
      end else begin
         busyMeta <= calBusyIn;
         busySync <= busyMeta;
      end
   end

   // ***********************************************************
   // pin outputs
   // ***********************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         multiplexedOutputPin <= 1'b0;
      end else begin
         multiplexedOutputPin <= ctrl.readoutPinSelect ? lockSync : rbSync;
      end
   end

   // mute follows the engine's busy flag only while the mute bit is set
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rfMute <= 1'b0;
      end else begin
         rfMute <= busySync && ctrl.calOutputMute;
      end
   end

   // ***********************************************************
   // cal state machine clock enable: one in 2^div cycles
   // ***********************************************************
   // last count of a divider period; code 7 still fits the 8-bit counter
   function automatic logic [7:0] divTerminal(input logic [2:0] div);
      divTerminal = (8'h01 << div) - 8'h01;
   endfunction : divTerminal

   always_comb begin
      divLimit = divTerminal(ctrl.calClockDiv);
   end

   // counter is held clear while no calibration runs, so every run
   // starts with a full divider period
   always_ff @(posedge ref_clk) begin
      if (rst || !busySync) begin
         divCount         <= 8'h00;
         calSmClockEnable <= 1'b0;
      end else begin
         if (divCount >= divLimit) begin
            divCount         <= 8'h00;
            calSmClockEnable <= 1'b1;
         end else begin
            divCount         <= divCount + 8'h01;
            calSmClockEnable <= 1'b0;
         end
      end
   end

endmodule : scr_control_regs

//--- hw/scr_params.svh
// constants for the synthesizer control register bank
// assumes inclusion by the bank package, compiled ahead of the bank module
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH
// register indices and byte addresses (index times four)
`define SCR_IDX_MAIN        2'h0
`define SCR_IDX_CALDIV      2'h1
`define SCR_IDX_FIXED2      2'h2
`define SCR_ADDR_MAIN       12'h000
`define SCR_ADDR_CALDIV     12'h004
`define SCR_ADDR_FIXED2     12'h008
// reset values
`define SCR_RST_MAIN        16'h221C
`define SCR_RST_CALDIV      16'h0808
`define SCR_RST_FIXED2      16'h0500
// main control word field positions
`define SCR_B_RAMP_GO       15
`define SCR_B_PHASE_SYNC    14
`define SCR_B_ADDR_FREEZE   11
`define SCR_B_OUT_MUTE      9
`define SCR_B_HPD_HI        8
`define SCR_B_HPD_LO        7
`define SCR_B_LPD_HI        6
`define SCR_B_LPD_LO        5
`define SCR_B_CAL_TRIGGER   3
`define SCR_B_READOUT_SEL   2
`define SCR_B_SOFT_RESET    1
`define SCR_B_SLEEP         0
// cal divider field
`define SCR_B_DIV_HI        2
`define SCR_B_DIV_LO        0
// timing: one wait state on every access
`define SCR_WAIT_CYCLES     1
`endif

//--- hw/scr_pkg.sv
// types for the synthesizer control register bank
// assumes scr_params.svh is on the include path
package scr_pkg;
`include "scr_params.svh"

   typedef logic [15:0] scr_word_t;

   typedef struct packed {
      logic       rampStart;
      logic       calStart;
      logic       syncPulse;
      logic       phaseSyncEnable;
      logic       addrFreeze;
      logic       calOutputMute;
      logic [1:0] highPdRange;
      logic [1:0] lowPdRange;
      logic       readoutPinSelect;
      logic       sleepRequest;
      logic [2:0] calClockDiv;
   } scr_ctrl_s;

   typedef enum logic [1:0] {
      SCR_IDLE   = 2'b00,
      SCR_ACCESS = 2'b01,
      SCR_DONE   = 2'b11
   } scr_state_e;
endpackage : scr_pkg

//--- verification/scr_control_regs_props.sv
// checker for the synthesizer control register bank
// assumes bind onto scr_control_regs, single ref_clk domain
`timescale 1ns/10ps
module scr_control_regs_props
   import scr_pkg::*;
(
   // watched ports
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        calSmClockEnable,
   input wire scr_ctrl_s   ctrl
);
   // ****
   // properties
   // ****
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic wrMain;
   assign wrMain = psel && penable && pready && pwrite && paddr == 12'h000 && pstrb[1:0] == 2'h3;
   sequence oneWait; !pready ##1 pready; endsequence
   sequence syncRise; !ctrl.phaseSyncEnable ##1 ctrl.phaseSyncEnable; endsequence
   a_one_wait_state: assert property (psel && !penable |=> oneWait)
      else $error("pready not after one wait state");
   a_err_unmapped: assert property (psel && penable && pready |-> pslverr == !(paddr inside {0, 4, 8}))
      else $error("pslverr wrong for address");
   a_ramp_on_write: assert property (wrMain && pwdata[15] |=> ctrl.rampStart)
      else $error("ramp start missing");
   a_cal_on_write: assert property (wrMain && pwdata[3] |=> ctrl.calStart)
      else $error("cal start missing");
   a_pulse_after_word: assert property (ctrl.calStart |-> $past(wrMain))
      else $error("cal start without full write");
   a_sync_on_rise: assert property (ctrl.syncPulse |-> syncRise)
      else $error("sync pulse without rise");
   a_soft_reset_defaults: assert property (wrMain && pwdata[1] |-> ##2 ctrl.calOutputMute && ctrl.readoutPinSelect
      && ctrl.calClockDiv == 3'h0 && !ctrl.sleepRequest) else $error("soft reset did not restore");
   a_sleep_level: assert property (wrMain && pwdata[0] && !pwdata[1] |-> ##2 ctrl.sleepRequest)
      else $error("sleep not set");
   a_reset_levels: assert property ($fell(rst) |-> ctrl.calOutputMute && ctrl.readoutPinSelect)
      else $error("reset levels wrong");
   a_div_spacing: assert property (calSmClockEnable && ctrl.calClockDiv == 3'h1 |=> !calSmClockEnable)
      else $error("cal clock enable too close");
endmodule : scr_control_regs_props

bind scr_control_regs scr_control_regs_props scr_control_regs_props_inst (.ref_clk, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .calSmClockEnable, .ctrl);

//--- verification/scr_control_regs_tb_top.sv
// self-checking bench for the synthesizer control register bank
// assumes scr_pkg, the bank and its checker are compiled first
`timescale 1ns/10ps
module scr_control_regs_tb_top
   import scr_pkg::*;
;
   logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        lockIn = 1'b0, rbIn = 1'b0, busyIn = 1'b0, err, pready, pslverr, muxPin, rfMute, smEn;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'hF;
   logic [31:0] rstv [3] = '{32'h221C, 32'h0808, 32'h0500};
   scr_ctrl_s   ctrl;
   int          failCount = 0, nChecks = 0, cycles = 0, nRamp = 0, nCal = 0, nSync = 0, nEn = 0, base;

   scr_control_regs scr_control_regs_inst (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .lockDetectIn(lockIn), .readbackBitIn(rbIn), .calBusyIn(busyIn),
      .ctrl, .multiplexedOutputPin(muxPin), .rfMute, .calSmClockEnable(smEn));

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      nRamp <= nRamp + ctrl.rampStart;
      nCal <= nCal + ctrl.calStart;
      nSync <= nSync + ctrl.syncPulse;
      nEn <= nEn + smEn;
      if (cycles == 2000) begin
         failCount++;
         printVerdict();
      end
   end

   // ****
   // tasks
   // ****
   task automatic printVerdict();
      if (failCount == 0 && nChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : printVerdict

   task automatic chkW(input string nm, input logic [31:0] exp, input logic [31:0] got);
      nChecks++;
      if (got !== exp) begin
         failCount++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chkW

   task automatic chkN(input string nm, input int exp, input int got);
      nChecks++;
      if (got != exp) begin
         failCount++;
         $display("BAD %s expected %0d seen %0d", nm, exp, got);
      end
   endtask : chkN

   // one apb transfer; data and response are taken at the ready edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chkDefaults();
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chkW("register default", rstv[i], rd);
      end
   endtask : chkDefaults

   // ****
   // tests
   // ****
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      chkDefaults();
      apb(1'b1, 12'h00C, 32'h0000FFFF);
      apb(1'b0, 12'h00C, 32'h0);
      chkW("unmapped err", 32'h1, {31'h0, err});
      chkW("unmapped data", 32'h0, rd);
      apb(1'b1, 12'h000, 32'h0000A21C);
      apb(1'b1, 12'h000, 32'h0000621C);
      apb(1'b1, 12'h000, 32'h0000621C);
      repeat (2) @(posedge ref_clk);
      chkN("ramp starts", 1, nRamp);
      chkN("cal starts", 3, nCal);
      chkN("sync pulses", 1, nSync);
      chkW("phase sync", 32'h1, {31'h0, ctrl.phaseSyncEnable});
      {lockIn, rbIn, busyIn} <= 3'b101;
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, 12'h000, i == 0 ? 32'h00002BFD : 32'h00002018);
         repeat (5) @(posedge ref_clk);
         if (i == 0) chkW("fields", 32'h3F, {26'h0, ctrl.addrFreeze, ctrl.highPdRange, ctrl.lowPdRange, ctrl.sleepRequest});
         chkW("mux pin", 32'(i == 0), {31'h0, muxPin});
         chkW("rf mute", 32'(i == 0), {31'h0, rfMute});
      end
      for (int i = 0; i < 2; i++) begin
         busyIn <= 1'b0;
         apb(1'b1, 12'h004, 32'h00000809 - i);
         busyIn <= 1'b1;
         repeat (6) @(posedge ref_clk);
         base = nEn;
         repeat (16) @(posedge ref_clk);
         chkN("cal clock enables", 8 << i, nEn - base);
      end
      apb(1'b1, 12'h008, 32'h00000500);
      apb(1'b1, 12'h004, 32'h00000809);
      apb(1'b1, 12'h000, 32'h0000221E);
      chkDefaults();
      printVerdict();
   end
endmodule : scr_control_regs_tb_top
